// *** verilog/udq_pkg.sv ***
// package: register map, field layout and reset values of the dma queue state block
package udq_pkg;
   // ==========================================================
   // register byte offsets (chosen, word aligned)
   localparam logic [5:0] ADDR_RX_TALLY0   = 6'h00;
   localparam logic [5:0] ADDR_RX_TALLY1   = 6'h04;
   localparam logic [5:0] ADDR_RX_TALLY2   = 6'h08;
   localparam logic [5:0] ADDR_RX_TALLY3   = 6'h0c;
   localparam logic [5:0] ADDR_TX_HEAD     = 6'h10;
   localparam logic [5:0] ADDR_TX_START    = 6'h14;
   localparam logic [5:0] ADDR_DMA_CTRL    = 6'h18;
   localparam logic [5:0] ADDR_DMA_STATUS  = 6'h1c;
   // ==========================================================
   // field layout
   localparam int         TALLY_W          = 16;
   localparam int         PTR_LSB          = 2;
   localparam int         PTR_W            = 30;
   localparam int         IN_PKT_BIT       = 0;
   localparam int         NUM_RX_CHAN      = 4;
   localparam int         MIN_RX_BUFFERS   = 3;
   localparam int         CTRL_ENABLE_BIT  = 0;
   // ==========================================================
   // reset values and fifo shape
   localparam logic [15:0] TALLY_RESET     = 16'h0000;
   localparam logic [29:0] PTR_RESET       = 30'h00000000;
   localparam int          FIFO_W          = 32;
   localparam int          FIFO_D          = 4;
   localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;
endpackage

// *** verilog/udq_fifo.sv ***
// small synchronous valid/ready fifo
`timescale 1ns/1ps
module udq_fifo
   import udq_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    wr_ptr_next;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [AW:0]      fill_reg;
   logic [AW:0]      fill_next;
   logic             push;
   logic             pop;

   // ==========================================================
   // pointer and fill bookkeeping
   always_comb
   begin
      push        = in_valid && (fill_reg != (AW+1)'(DEPTH));
      pop         = out_ready && (fill_reg != '0);
      wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      fill_next   = fill_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg   <= '0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         fill_reg   <= fill_next;
      end
   end

   // storage has no reset; out_data shows the slot at the read pointer even while empty
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

   assign in_ready  = (fill_reg != (AW+1)'(DEPTH)); // honest full
   assign out_valid = (fill_reg != '0);             // honest empty
   assign out_data  = mem_reg[rd_ptr_reg];
endmodule // udq_fifo

// *** verilog/udq_queue_regs.sv ***
// dma queue state registers with avalon-mm slave and tx descriptor fifo
// Functional notes
// - four 16-bit receive buffer tallies, readable
// - tally write adds value, never replaces
// - word0 bits 31-2 hold queue head pointer
// - word0 bit0 shows packet in progress
// - word1 bits 31-2 hold first descriptor pointer
// - word1 bit0 also shows packet in progress
`timescale 1ns/1ps
module udq_queue_regs
   import udq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [31:0] desc_addr,
   output logic             desc_valid,
   input  wire logic        desc_ready,
   input  wire logic        pkt_start,
   input  wire logic        pkt_end,
   input  wire logic [3:0]  rx_consume,
   output logic             dma_enable,
   output logic      [3:0]  rx_chan_ready
);
   typedef enum logic [1:0] {ST_IDLE, ST_ANSWER, ST_RELEASE} udq_bus_type;

   // byte address of a 30-bit descriptor pointer
   function automatic logic [31:0] ptr_to_addr(input logic [29:0] ptr);
      ptr_to_addr = {ptr, 2'b00};
   endfunction

   // merge written byte lanes over an old word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  be);
      for (int i = 0; i < 4; i++)
         lane_merge[8*i +: 8] = be[i] ? new_word[8*i +: 8] : old_word[8*i +: 8];
   endfunction

   udq_bus_type  bus_state_reg;
   udq_bus_type  bus_state_next;
   logic [31:0]  rdata_reg;
   logic [31:0]  rdata_next;
   logic [15:0]  tally_reg [NUM_RX_CHAN];
   logic [15:0]  tally_next [NUM_RX_CHAN];
   logic [29:0]  head_ptr_reg;
   logic [29:0]  head_ptr_next;
   logic [29:0]  start_ptr_reg;
   logic [29:0]  start_ptr_next;
   logic         in_pkt_reg;
   logic         in_pkt_next;
   logic         enable_reg;
   logic         enable_next;
   logic [31:0]  desc_addr_reg;
   logic         desc_valid_reg;
   logic [3:0]   chan_ready_reg;
   logic [3:0]   chan_ready_next;
   logic         wait_reg;
   logic         wait_next;
   logic [31:0]  desc_addr_next;
   logic         desc_valid_next;
   logic         fifo_in_valid;
   logic         fifo_in_ready;
   logic [31:0]  fifo_out_data;
   logic         fifo_out_valid;
   logic         fifo_out_ready;
   logic         wr_go;
   logic [31:0]  wmerged;
   logic [31:0]  wmask;
   logic [15:0]  add_val;

   // ==========================================================
   // bus handshake: request held, taken once, answered next cycle
   // the edge that finds the state idle with read or write high takes
   // the request; waitrequest drops for exactly the following cycle and
   // the master completes there. one release cycle follows, so a request
   // that is held one cycle past its answer is not taken a second time.
   // the cost is a fixed three-cycle pitch for back-to-back accesses,
   // which is cheap next to the descriptor traffic behind this block.
   assign wr_go = (bus_state_reg == ST_IDLE) && avs_write;

   always_comb
   begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         ST_IDLE:    if (avs_read || avs_write) bus_state_next = ST_ANSWER;
         ST_ANSWER:  bus_state_next = ST_RELEASE;
         ST_RELEASE: bus_state_next = ST_IDLE;
         default:    bus_state_next = ST_IDLE;
      endcase
      // registered from the next state so the port comes from a flop
      wait_next = (bus_state_next != ST_ANSWER);
   end

   // ==========================================================
   // read mux, captured when the request is taken
   // the answer cycle shows the value of the taking edge, so a write
   // landing in the same access cannot tear a read. bit 1 of both state
   // words and every unmapped word read zero.
   always_comb
   begin
      rdata_next = rdata_reg;
      if ((bus_state_reg == ST_IDLE) && avs_read)
      begin
         case (avs_address)
            ADDR_RX_TALLY0:  rdata_next = {16'h0000, tally_reg[0]};
            ADDR_RX_TALLY1:  rdata_next = {16'h0000, tally_reg[1]};
            ADDR_RX_TALLY2:  rdata_next = {16'h0000, tally_reg[2]};
            ADDR_RX_TALLY3:  rdata_next = {16'h0000, tally_reg[3]};
            ADDR_TX_HEAD:    rdata_next = {head_ptr_reg, 1'b0, in_pkt_reg};
            ADDR_TX_START:   rdata_next = {start_ptr_reg, 1'b0, in_pkt_reg};
            ADDR_DMA_CTRL:   rdata_next = {31'h00000000, enable_reg};
            ADDR_DMA_STATUS: rdata_next = {27'h0000000, ~fifo_in_ready, chan_ready_reg};
            default:         rdata_next = UNMAPPED_READ;
         endcase
      end
   end

   // ==========================================================
   // tally counters: writes add, receive consumption subtracts
   // only the enabled low lanes add; the upper half is reserved and a
   // write there adds nothing. the sum wraps at 16 bits, so software
   // that overfills a queue loses count; nothing flags the wrap.
   // a write and a consume in one cycle both apply.
   always_comb
   begin
      wmask   = lane_merge(32'h00000000, 32'hffffffff, avs_byteenable);
      add_val = avs_writedata[15:0] & wmask[15:0];
      for (int c = 0; c < NUM_RX_CHAN; c++)
      begin
         tally_next[c] = tally_reg[c];
         if (wr_go && (avs_address == ADDR_RX_TALLY0 + 6'(4*c)))
            tally_next[c] = tally_next[c] + add_val;
         // counter saturates at zero; a consume on an empty queue is dropped
         if (rx_consume[c] && (tally_next[c] != 16'h0000))
            tally_next[c] = tally_next[c] - 16'h0001;
         // dma for a channel only runs once enough buffers are queued
         chan_ready_next[c] = enable_reg &&
                              (tally_reg[c] >= 16'(MIN_RX_BUFFERS));
      end
   end

   // ==========================================================
   // tx state words and enable; packet strobes beat software writes
   // the in-packet flag is one bit shared by both state words, so a
   // write to either word's bit 0 moves it for both. a packet start
   // wins over a write and over a packet end in the same cycle; a
   // start refused for a full queue leaves both words untouched.
   always_comb
   begin
      wmerged        = lane_merge({head_ptr_reg, 1'b0, in_pkt_reg}, avs_writedata,
                                  avs_byteenable);
      head_ptr_next  = head_ptr_reg;
      start_ptr_next = start_ptr_reg;
      in_pkt_next    = in_pkt_reg;
      enable_next    = enable_reg;
      fifo_in_valid  = 1'b0;
      if (wr_go && avs_address == ADDR_TX_HEAD)
      begin
         head_ptr_next = wmerged[31:PTR_LSB];
         in_pkt_next   = wmerged[IN_PKT_BIT];
      end
      if (wr_go && avs_address == ADDR_TX_START)
      begin
         wmerged        = lane_merge({start_ptr_reg, 1'b0, in_pkt_reg}, avs_writedata,
                                     avs_byteenable);
         start_ptr_next = wmerged[31:PTR_LSB];
         in_pkt_next    = wmerged[IN_PKT_BIT];
      end
      if (wr_go && avs_address == ADDR_DMA_CTRL && avs_byteenable[0])
         enable_next = avs_writedata[CTRL_ENABLE_BIT];
      // a new packet latches the head as its first descriptor
      if (pkt_start && enable_reg && fifo_in_ready)
      begin
         fifo_in_valid  = 1'b1;
         start_ptr_next = head_ptr_reg;
         in_pkt_next    = 1'b1;
      end
      else if (pkt_end)
         in_pkt_next = 1'b0;
   end

   // ==========================================================
   // descriptor fetch queue toward memory
   // four words wait here and one more in the output stage, so five
   // starts are held while memory stalls; a sixth is refused
   udq_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) i_udq_fifo
   (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_data   (ptr_to_addr(head_ptr_reg)),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );

   // ==========================================================
   // output stage: holds a descriptor until memory takes it
   // memory may hold desc_ready low for any time; the stage just waits
   assign fifo_out_ready = !desc_valid_reg || desc_ready;

   // load a new word whenever the stage is empty or being emptied
   always_comb
   begin
      desc_valid_next = desc_valid_reg;
      desc_addr_next  = desc_addr_reg;
      if (fifo_out_ready)
      begin
         desc_valid_next = fifo_out_valid;
         desc_addr_next  = fifo_out_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         desc_valid_reg <= 1'b0;
         desc_addr_reg  <= 32'h00000000;
      end
      else
      begin
         desc_valid_reg <= desc_valid_next;
         desc_addr_reg  <= desc_addr_next;
      end
   end

   // ==========================================================
   // bus state, waitrequest and read data registers
   // rdata holds until the next read is taken
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         bus_state_reg <= ST_IDLE;
         wait_reg      <= 1'b1;
         rdata_reg     <= 32'h00000000;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         wait_reg      <= wait_next;
         rdata_reg     <= rdata_next;
      end
   end

   // ==========================================================
   // receive tallies and channel ready flags
   // ready flags lag the tallies by one cycle
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         chan_ready_reg <= 4'h0;
         for (int c = 0; c < NUM_RX_CHAN; c++)
            tally_reg[c] <= TALLY_RESET;
      end
      else
      begin
         chan_ready_reg <= chan_ready_next;
         for (int c = 0; c < NUM_RX_CHAN; c++)
            tally_reg[c] <= tally_next[c];
      end
   end

   // ==========================================================
   // transmit state words and dma enable
   // pointers reset to zero, an aligned but meaningless head
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         head_ptr_reg  <= PTR_RESET;
         start_ptr_reg <= PTR_RESET;
         in_pkt_reg    <= 1'b0;
         enable_reg    <= 1'b0;
      end
      else
      begin
         head_ptr_reg  <= head_ptr_next;
         start_ptr_reg <= start_ptr_next;
         in_pkt_reg    <= in_pkt_next;
         enable_reg    <= enable_next;
      end
   end

   // ==========================================================
   // every port below is a plain register output
   // no output is decoded from state, so none can glitch
   assign avs_waitrequest = wait_reg;
   assign avs_readdata    = rdata_reg;
   assign desc_addr       = desc_addr_reg;
   assign desc_valid      = desc_valid_reg;
   assign dma_enable      = enable_reg;
   assign rx_chan_ready   = chan_ready_reg;
endmodule // udq_queue_regs

// *** dv/udq_desc_mem.sv ***
// descriptor memory model: accepts fetch addresses, stalls on demand
`timescale 1ns/1ps
module udq_desc_mem
   import udq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [31:0] desc_addr,
   input  wire logic        desc_valid,
   input  wire logic        stall,
   output logic             desc_ready,
   output logic      [31:0] last_addr,
   output int               taken
);
   // ==========================================
   // a slow memory simply holds ready low
   assign desc_ready = !stall;
   // fetch log, checked by the bench
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         taken     <= 0;
         last_addr <= 32'h00000000;
      end
      else if (desc_valid && desc_ready)
      begin
         taken     <= taken + 1;
         last_addr <= desc_addr;
      end
   end
endmodule // udq_desc_mem

// *** dv/udq_queue_regs_asserts.sv ***
// checker: bus handshake, read fields and descriptor hand-off
`timescale 1ns/1ps
module udq_queue_regs_asserts
   import udq_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] desc_addr,
   input wire logic        desc_valid,
   input wire logic        desc_ready,
   input wire logic        pkt_start,
   input wire logic        dma_enable,
   input wire logic [3:0]  rx_chan_ready
);
   // ==========================================
   // read answer cycle
   logic ans;
   assign ans = avs_read && !avs_waitrequest;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ==========================================
   // properties
   property p_wait; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
   property p_answer; $rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest; endproperty
   property p_tally_hi; ans && avs_address < ADDR_TX_HEAD |-> avs_readdata[31:16] == 16'h0000;
   endproperty
   property p_unmapped; ans && avs_address >= 6'h20 |-> avs_readdata == UNMAPPED_READ;
   endproperty
   property p_resv; ans && avs_address[5:3] == 3'b010 |-> !avs_readdata[1]; endproperty
   property p_hold; desc_valid && !desc_ready |=> desc_valid && $stable(desc_addr); endproperty
   property p_align; desc_valid |-> desc_addr[1:0] == 2'b00; endproperty
   property p_launch; pkt_start && dma_enable && !desc_valid |-> ##2 desc_valid; endproperty
   property p_chan_en; rx_chan_ready != 4'h0 |-> $past(dma_enable); endproperty
   a_wait: assert property (p_wait) else $error("waitrequest low too long");
   a_answer: assert property (p_answer) else $error("no bus answer");
   a_tally_hi: assert property (p_tally_hi) else $error("tally upper bits set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_resv: assert property (p_resv) else $error("state word bit1 set");
   a_hold: assert property (p_hold) else $error("descriptor dropped");
   a_align: assert property (p_align) else $error("descriptor unaligned");
   a_launch: assert property (p_launch) else $error("descriptor not offered");
   a_chan_en: assert property (p_chan_en) else $error("ready while disabled");
   c_read: cover property (ans);
   c_stall: cover property (desc_valid && !desc_ready ##1 desc_valid && desc_ready);
   c_ready: cover property (rx_chan_ready == 4'hf);
endmodule // udq_queue_regs_asserts

bind udq_queue_regs udq_queue_regs_asserts i_udq_queue_regs_asserts (
   .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .desc_addr(desc_addr), .desc_valid(desc_valid), .desc_ready(desc_ready),
   .pkt_start(pkt_start), .dma_enable(dma_enable), .rx_chan_ready(rx_chan_ready));

// *** dv/usb_dma_queue_state_regs_tb_top.sv ***
// testbench: register bus sequences against the queue state block
`timescale 1ns/1ps
module usb_dma_queue_state_regs_tb_top;
   import udq_pkg::*;
   logic        clk_sys, avs_waitrequest, desc_valid, desc_ready, dma_enable;
   logic        srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic        pkt_start = 1'b0, pkt_end = 1'b0, stall = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic [3:0]  avs_byteenable = 4'hf, rx_consume = 4'h0, rx_chan_ready;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, desc_addr, last_addr, rd;
   logic [31:0] exp_t [4] = '{32'h2, 32'h104, 32'h5, 32'h5};
   int          failures = 0, cmp_count = 0, taken;
   // ==========================================
   // design, memory model, clock
   udq_queue_regs i_udq_queue_regs (.clk_sys(clk_sys), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .desc_addr(desc_addr), .desc_valid(desc_valid), .desc_ready(desc_ready),
      .pkt_start(pkt_start), .pkt_end(pkt_end), .rx_consume(rx_consume),
      .dma_enable(dma_enable), .rx_chan_ready(rx_chan_ready));
   udq_desc_mem i_udq_desc_mem (.clk_sys(clk_sys), .srst(srst), .desc_addr(desc_addr),
      .desc_valid(desc_valid), .stall(stall), .desc_ready(desc_ready),
      .last_addr(last_addr), .taken(taken));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one bus cycle; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
      @(posedge clk_sys);
      avs_address    <= a;
      avs_write      <= w;
      avs_read       <= !w;
      avs_writedata  <= d;
      avs_byteenable <= be;
      do
         @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================
   // sequence
   initial
   begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      // every register and one unmapped place read zero after reset
      for (int i = 0; i < 9; i++)
      begin
         bus(1'b0, 6'(4 * i), 32'h0);
         chk(rd, 32'h0, "reset read");
      end
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, 6'(4 * c), 32'h2);
         bus(1'b1, 6'(4 * c), 32'(c + 1));
         bus(1'b0, 6'(4 * c), 32'h0);
         chk(rd, 32'(c + 3), "tally add");
      end
      // lane merge, upper half ignored, 16-bit wrap
      bus(1'b1, ADDR_RX_TALLY1, 32'h00000100, 4'h2);
      bus(1'b1, ADDR_RX_TALLY2, 32'h00010000);
      bus(1'b1, ADDR_RX_TALLY3, 32'h0000ffff);
      bus(1'b1, ADDR_DMA_CTRL, 32'h1);
      bus(1'b0, ADDR_DMA_CTRL, 32'h0);
      chk(rd, 32'h00000001, "ctrl word");
      bus(1'b0, ADDR_DMA_STATUS, 32'h0);
      chk(rd, 32'h0000000f, "chan ready");
      chk(32'(dma_enable), 32'h1, "enable port");
      chk(32'(rx_chan_ready), 32'hf, "chan ready port");
      @(posedge clk_sys);
      rx_consume <= 4'h1;
      @(posedge clk_sys);
      rx_consume <= 4'h0;
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b0, 6'(4 * c), 32'h0);
         chk(rd, exp_t[c], "tally value");
      end
      bus(1'b0, ADDR_DMA_STATUS, 32'h0);
      chk(rd, 32'h0000000e, "chan ready");
      chk(32'(rx_chan_ready), 32'he, "chan ready port");
      bus(1'b1, ADDR_TX_HEAD, 32'h1234567b);
      bus(1'b0, ADDR_TX_HEAD, 32'h0);
      chk(rd, 32'h12345679, "head word");
      bus(1'b0, ADDR_TX_START, 32'h0);
      chk(rd, 32'h00000001, "start flag");
      @(posedge clk_sys);
      pkt_end <= 1'b1;
      @(posedge clk_sys);
      pkt_end <= 1'b0;
      bus(1'b0, ADDR_TX_HEAD, 32'h0);
      chk(rd, 32'h12345678, "packet end");
      // start word written through one lane; flag is shared with word 0
      bus(1'b1, ADDR_TX_START, 32'hffff5557, 4'h1);
      bus(1'b0, ADDR_TX_START, 32'h0);
      chk(rd, 32'h00000055, "start write");
      bus(1'b0, ADDR_TX_HEAD, 32'h0);
      chk(rd, 32'h12345679, "shared flag");
      // memory stalls while six packets start: stage plus four fit
      stall <= 1'b1;
      repeat (6)
      begin
         @(posedge clk_sys);
         pkt_start <= 1'b1;
         @(posedge clk_sys);
         pkt_start <= 1'b0;
      end
      bus(1'b0, ADDR_TX_START, 32'h0);
      chk(rd, 32'h12345679, "start word");
      bus(1'b0, ADDR_DMA_STATUS, 32'h0);
      chk(rd, 32'h0000001e, "fifo full");
      stall <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(32'(taken), 32'h5, "fetch count");
      chk(last_addr, 32'h12345678, "fetch addr");
      tally_and_finish();
   end
   // watchdog: the sequence needs well under 2000 cycles
   initial
   begin
      #20000;
      failures++;
      tally_and_finish();
   end
endmodule // usb_dma_queue_state_regs_tb_top
